// [host_port_model.sv]
// Host processor model: parallel and serial register accesses.
// Assumes the device samples host pins on rising clk; all pins change at falling edges.
`timescale 1ns/10ps
module host_port_model (
  // Clock and mode
  input wire logic clk,
  input wire logic mux_sel,
  // Parallel port
  output logic par_rd,
  output logic par_wr,
  output logic par_ale,
  output logic [7:0] par_addr,
  output logic [7:0] par_data_in,
  input wire logic [7:0] par_data_out,
  input wire logic par_data_valid,
  // Serial port
  output logic ser_clk,
  output logic ser_cs_n,
  output logic ser_di,
  input wire logic ser_do
);
  import line_unit_pkg::*;

  initial begin
    par_rd = 1'b0;
    par_wr = 1'b0;
    par_ale = 1'b0;
    par_addr = 8'h00;
    par_data_in = 8'h00;
    ser_clk = 1'b0;
    ser_cs_n = 1'b1;
    ser_di = 1'b0;
  end

  // Deselected data line toggles so a stale bit never looks driven
  always @(negedge clk) begin
    if (ser_cs_n) begin
      ser_di <= ~ser_di;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Upper address bits set on purpose; device must drop them
  task automatic put_addr(input logic [7:0] a);
    if (mux_sel) begin
      par_ale = 1'b1;
      par_data_in = a;
      @(negedge clk);
      par_ale = 1'b0;
    end else begin
      par_addr = a;
    end
  endtask

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    put_addr(a);
    par_data_in = d;
    par_wr = 1'b1;
    @(negedge clk);
    par_wr = 1'b0;
    par_data_in = ~d;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk);
    put_addr(a);
    par_rd = 1'b1;
    @(negedge clk);
    par_rd = 1'b0;
    for (n = 0; n < 4 && par_data_valid !== 1'b1; n++) begin
      @(negedge clk);
    end
    d = (par_data_valid === 1'b1) ? par_data_out : 8'hXX;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Slow serial clock: six clk per phase covers the pin synchronisers
  task automatic ser_xfer(input logic rd, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    w = {d, 2'b11, a, rd};
    @(negedge clk);
    ser_cs_n = 1'b0;
    // One idle cycle so the deselect toggler has let go of the data line
    @(negedge clk);
    for (int i = 0; i < SER_BITS; i++) begin
      ser_di = w[i];
      repeat (6) @(negedge clk);
      if (i >= SER_CMD_BITS) begin
        q[i - SER_CMD_BITS] = ser_do;
      end
      ser_clk = 1'b1;
      repeat (6) @(negedge clk);
      ser_clk = 1'b0;
    end
    repeat (6) @(negedge clk);
    ser_cs_n = 1'b1;
  endtask
endmodule

// [line_unit_pkg.sv]
// Shared constants and types for the octal line unit register bank.
// Assumes one clock domain; host strobes arrive already in that domain.
package line_unit_pkg;

  localparam int ADDR_W = 5;
  localparam int NUM_CH = 8;
  localparam int NUM_SRC = 3;

  // Primary bank offsets
  localparam logic [4:0] OFS_DEVICE_IDENTITY = 5'h00;
  localparam logic [4:0] OFS_ANALOG_LOOP = 5'h01;
  localparam logic [4:0] OFS_REMOTE_LOOP = 5'h02;
  localparam logic [4:0] OFS_ALL_ONES_TX = 5'h03;
  localparam logic [4:0] OFS_SIGNAL_LOSS_STATE = 5'h04;
  localparam logic [4:0] OFS_SHORT_CIRCUIT_STATE = 5'h05;
  localparam logic [4:0] OFS_SIGNAL_LOSS_MASK = 5'h06;
  localparam logic [4:0] OFS_SHORT_CIRCUIT_MASK = 5'h07;
  localparam logic [4:0] OFS_SIGNAL_LOSS_FLAGS = 5'h08;
  localparam logic [4:0] OFS_SHORT_CIRCUIT_FLAGS = 5'h09;
  localparam logic [4:0] OFS_SOFTWARE_RESET = 5'h0A;
  localparam logic [4:0] OFS_MONITOR_SELECT = 5'h0B;
  localparam logic [4:0] OFS_DIGITAL_LOOP = 5'h0C;
  localparam logic [4:0] OFS_LOSS_ALARM_CRITERIA = 5'h0D;
  localparam logic [4:0] OFS_AUTO_ALL_ONES = 5'h0E;
  localparam logic [4:0] OFS_GLOBAL_CONFIG = 5'h0F;
  localparam logic [4:0] OFS_OUTPUT_ENABLE = 5'h12;
  localparam logic [4:0] OFS_ALARM_SIGNAL_STATE = 5'h13;
  localparam logic [4:0] OFS_ALARM_SIGNAL_MASK = 5'h14;
  localparam logic [4:0] OFS_ALARM_SIGNAL_FLAGS = 5'h15;
  localparam logic [4:0] OFS_BANK_POINTER = 5'h1F;

  // One bit per primary offset that software may write and read back
  localparam logic [31:0] RW_MAP = 32'h0014F8CE;

  localparam logic [7:0] BANK_EXPANDED = 8'hAA;
  localparam logic [7:0] BANK_PRIMARY = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int EXP_DEPTH = 16;

  // Monitor select field and serial word bit counts
  localparam int MON_CH_LSB = 0;
  localparam int MON_DIR_BIT = 3;
  localparam int SER_BITS = 16;
  localparam int SER_CMD_BITS = 8;

  typedef enum logic [1:0] {
    MODE_HARDWARE = 2'b00,
    MODE_PAR_DEMUX = 2'b01,
    MODE_PAR_MUX = 2'b10,
    MODE_SERIAL = 2'b11
  } host_mode_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } rail_pair_t;

endpackage

// [line_unit_regmap_monitor.sv]
// Register bank, bank pointer, interrupt flags and channel-0 monitor select.
// Parallel strobes come from logic on clk; serial and select pins are synchronised here.
`timescale 1ns/10ps

// Function
// - Channel 0 observes one of channels 1..7
// - Select from pins or monitor register
// - Monitored signal feeds channel-0 clock recovery
// - Recovered data on channel-0 receive outputs
// - Loss detector sees the monitored signal
// - Remote loop drives monitored signal to transmit
// - Five address bits; upper bits ignored
// - Address bits chosen per host mode
// - Bank pointer at 1F selects bank
// - Value AA selects sixteen expanded registers
// - Zero returns to primary bank
// - Read-only status at 04, 05, 13
// - Mask registers at 06, 07, 14
// - Interrupt flags at 08, 09, 15
// - Write to 0A triggers software reset
// - Loopback registers at 01, 02, 0C
// - All-ones registers at 03, 0E
// - Registers at 12, 0D, 0F
// - Masked status change sets flag, asserts interrupt
// - Status read clears flags; interrupt released
// - Serial word: command byte, data byte
module line_unit_regmap_monitor
  import line_unit_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5A  // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host mode and parallel port
  input wire line_unit_pkg::host_mode_t host_mode,
  input wire logic par_rd,
  input wire logic par_wr,
  input wire logic par_ale,
  input wire logic [7:0] par_addr,
  input wire logic [7:0] par_data_in,
  output logic [7:0] par_data_out,
  output logic par_data_valid,
  // Serial port
  input wire logic ser_clk,
  input wire logic ser_cs_n,
  input wire logic ser_di,
  output logic ser_do,
  // Detector status inputs
  input wire logic [7:0] signal_loss_in,
  input wire logic [7:0] short_circuit_in,
  input wire logic [7:0] alarm_signal_in,
  // Interrupt pin, open drain
  output logic int_out,
  output logic int_oe,
  // Monitoring
  input wire logic [3:0] monitor_path_select_pins,
  input wire line_unit_pkg::rail_pair_t [7:0] line_rx_in,
  input wire line_unit_pkg::rail_pair_t [7:0] line_tx_in,
  input wire logic ch0_cdr_clock,
  input wire line_unit_pkg::rail_pair_t ch0_cdr_data,
  output line_unit_pkg::rail_pair_t ch0_cdr_in,
  output line_unit_pkg::rail_pair_t ch0_los_in,
  output logic ch0_receive_clock_out,
  output logic ch0_receive_data_pos_out,
  output logic ch0_receive_data_neg_out,
  output logic ch0_line_tx_tip,
  output logic ch0_line_tx_ring,
  // Configuration outputs
  output logic [7:0] analog_loop_config,
  output logic [7:0] remote_loop_config,
  output logic [7:0] digital_loop_config,
  output logic [7:0] all_ones_transmit_config,
  output logic [7:0] auto_all_ones_config,
  output logic [7:0] loss_alarm_criteria,
  output logic [7:0] global_config,
  output logic [7:0] output_enable_config,
  output logic monitoring_active,
  output logic software_reset_pulse
);
  import line_unit_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Serial port: pins synchronised before use
  logic [2:0] s_clk_q;
  logic [1:0] s_cs_q;
  logic [1:0] s_di_q;
  logic [4:0] s_cnt_q;
  logic [7:0] s_cmd_q;
  logic [7:0] s_data_q;
  logic [7:0] s_out_q;
  logic s_do_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_clk_q <= 3'h0;
      s_cs_q <= 2'h3;
      s_di_q <= 2'h0;
    end else begin
      s_clk_q <= {s_clk_q[1:0], ser_clk};
      s_cs_q <= {s_cs_q[0], ser_cs_n};
      s_di_q <= {s_di_q[0], ser_di};
    end
  end

  wire s_active = !s_cs_q[1];
  wire s_rise = s_active && s_clk_q[1] && !s_clk_q[2];
  wire s_fall = s_active && !s_clk_q[1] && s_clk_q[2];
  // Bits arrive LSB first: read/write, then address 1..5, then two ignored bits
  wire s_cmd_done = s_rise && (s_cnt_q == 5'(SER_CMD_BITS - 1));
  wire s_word_done = s_rise && (s_cnt_q == 5'(SER_BITS - 1));
  wire [7:0] s_cmd_next = {s_di_q[1], s_cmd_q[7:1]};
  wire [7:0] s_data_next = {s_di_q[1], s_data_q[7:1]};
  wire s_rd = s_cmd_done && s_cmd_next[0];
  wire s_wr = s_word_done && !s_cmd_q[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_cnt_q <= 5'h00;
      s_cmd_q <= 8'h00;
      s_data_q <= 8'h00;
    end else if (!s_active) begin
      s_cnt_q <= 5'h00;
    end else if (s_rise && s_cnt_q < 5'(SER_BITS)) begin
      s_cnt_q <= s_cnt_q + 5'h01;
      if (s_cnt_q < 5'(SER_CMD_BITS)) begin
        s_cmd_q <= s_cmd_next;
      end else begin
        s_data_q <= s_data_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host request selection and address decode
  logic [7:0] ad_latch_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_latch_q <= 8'h00;
    end else if (par_ale) begin
      ad_latch_q <= par_data_in;
    end
  end

  host_req_t req;
  wire par_mode = (host_mode == MODE_PAR_DEMUX) || (host_mode == MODE_PAR_MUX);
  wire ser_mode = (host_mode == MODE_SERIAL);
  // Only five bits take part; upper address bits never reach the decode
  wire [4:0] par_sel_addr = (host_mode == MODE_PAR_MUX) ? ad_latch_q[4:0] : par_addr[4:0];
  wire [4:0] ser_sel_addr = s_cmd_done ? s_cmd_next[5:1] : s_cmd_q[5:1];
  assign req.rd = (par_mode && par_rd) || (ser_mode && s_rd);
  assign req.wr = (par_mode && par_wr) || (ser_mode && s_wr);
  assign req.addr = ser_mode ? ser_sel_addr : par_sel_addr;
  assign req.wdata = ser_mode ? s_data_next : par_data_in;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] cfg_q [32];
  logic [7:0] exp_q [EXP_DEPTH];
  logic [7:0] bank_q;
  logic srst_q;

  wire is_ptr = (req.addr == OFS_BANK_POINTER);
  wire expanded = (bank_q == BANK_EXPANDED);
  wire prim_wr = req.wr && !is_ptr && !expanded && RW_MAP[req.addr];
  wire exp_wr = req.wr && !is_ptr && expanded && !req.addr[4];
  wire srst_wr = req.wr && !expanded && (req.addr == OFS_SOFTWARE_RESET);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_q <= BANK_PRIMARY;
      srst_q <= 1'b0;
    end else begin
      srst_q <= srst_wr;
      // Any value other than AA leaves the primary bank selected
      if (req.wr && is_ptr) begin
        bank_q <= req.wdata;
      end else if (srst_q) begin
        bank_q <= BANK_PRIMARY;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_cfg
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cfg_q[gi] <= REG_RESET;
        end else if (srst_q) begin
          cfg_q[gi] <= REG_RESET;
        end else if (prim_wr && req.addr == 5'(gi)) begin
          cfg_q[gi] <= req.wdata;
        end
      end
    end
    for (gi = 0; gi < EXP_DEPTH; gi++) begin : g_exp
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          exp_q[gi] <= REG_RESET;
        end else if (srst_q) begin
          exp_q[gi] <= REG_RESET;
        end else if (exp_wr && req.addr[3:0] == 4'(gi)) begin
          exp_q[gi] <= req.wdata;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Status, flags and interrupt; index 0 loss, 1 short, 2 alarm
  logic [7:0] stat_q [NUM_SRC];
  logic [7:0] flag_q [NUM_SRC];
  wire [7:0] stat_in [NUM_SRC];
  wire [7:0] mask [NUM_SRC];
  wire rd_clr [NUM_SRC];
  wire [NUM_SRC-1:0] pend;
  assign stat_in[0] = signal_loss_in;
  assign stat_in[1] = short_circuit_in;
  assign stat_in[2] = alarm_signal_in;
  assign mask[0] = cfg_q[OFS_SIGNAL_LOSS_MASK];
  assign mask[1] = cfg_q[OFS_SHORT_CIRCUIT_MASK];
  assign mask[2] = cfg_q[OFS_ALARM_SIGNAL_MASK];
  wire prim_rd = req.rd && !expanded;
  assign rd_clr[0] = prim_rd && req.addr == OFS_SIGNAL_LOSS_STATE;
  assign rd_clr[1] = prim_rd && req.addr == OFS_SHORT_CIRCUIT_STATE;
  assign rd_clr[2] = prim_rd && req.addr == OFS_ALARM_SIGNAL_STATE;

  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      // Either edge counts; a change in the clearing cycle still sets
      wire [7:0] chg = (stat_in[gi] ^ stat_q[gi]) & mask[gi];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stat_q[gi] <= 8'h00;
          flag_q[gi] <= 8'h00;
        end else begin
          stat_q[gi] <= stat_in[gi];
          flag_q[gi] <= (rd_clr[gi] ? 8'h00 : flag_q[gi]) | chg;
        end
      end
      assign pend[gi] = |flag_q[gi];
    end
  endgenerate

  assign int_out = 1'b0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_oe <= 1'b0;
    end else begin
      int_oe <= |pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (is_ptr) begin
      rd_mux = bank_q;
    end else if (expanded) begin
      rd_mux = req.addr[4] ? 8'h00 : exp_q[req.addr[3:0]];
    end else begin
      case (req.addr)
        OFS_DEVICE_IDENTITY: rd_mux = DEVICE_ID;
        OFS_SIGNAL_LOSS_STATE: rd_mux = stat_q[0];
        OFS_SHORT_CIRCUIT_STATE: rd_mux = stat_q[1];
        OFS_ALARM_SIGNAL_STATE: rd_mux = stat_q[2];
        OFS_SIGNAL_LOSS_FLAGS: rd_mux = flag_q[0];
        OFS_SHORT_CIRCUIT_FLAGS: rd_mux = flag_q[1];
        OFS_ALARM_SIGNAL_FLAGS: rd_mux = flag_q[2];
        default: rd_mux = RW_MAP[req.addr] ? cfg_q[req.addr] : 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      par_data_out <= 8'h00;
      par_data_valid <= 1'b0;
      s_out_q <= 8'h00;
      s_do_q <= 1'b0;
    end else begin
      par_data_valid <= par_mode && par_rd;
      if (par_mode && par_rd) begin
        par_data_out <= rd_mux;
      end
      // Serial data leaves LSB first on falling clock edges
      if (ser_mode && s_rd) begin
        s_out_q <= rd_mux;
      end else if (s_fall && s_cnt_q >= 5'(SER_CMD_BITS)) begin
        s_do_q <= s_out_q[0];
        s_out_q <= {1'b0, s_out_q[7:1]};
      end
    end
  end
  assign ser_do = s_do_q;

  ////////////////////////////////////////////////////////////////////////////
  // Monitor path select
  logic [3:0] msel_m_q;
  logic [3:0] msel_s_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msel_m_q <= 4'h0;
      msel_s_q <= 4'h0;
    end else begin
      msel_m_q <= monitor_path_select_pins;
      msel_s_q <= msel_m_q;
    end
  end

  wire [3:0] msel = (host_mode == MODE_HARDWARE) ? msel_s_q : cfg_q[OFS_MONITOR_SELECT][3:0];
  wire [2:0] mon_ch = msel[MON_CH_LSB +: 3];
  // Select 0 means channel 0 runs as a normal transceiver
  wire mon_on = (mon_ch != 3'h0);
  wire rail_pair_t mon_sig = msel[MON_DIR_BIT] ? line_tx_in[mon_ch] : line_rx_in[mon_ch];
  wire rail_pair_t cdr_src = mon_on ? mon_sig : line_rx_in[0];
  wire rl0 = remote_loop_config[0];
  // Remote loop in monitor mode sends the monitored signal out, not the recovered copy
  wire rail_pair_t tx_src = (mon_on && rl0) ? mon_sig : (rl0 ? ch0_cdr_data : line_tx_in[0]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ch0_cdr_in <= '0;
      ch0_los_in <= '0;
      ch0_receive_data_pos_out <= 1'b0;
      ch0_receive_data_neg_out <= 1'b0;
      ch0_line_tx_tip <= 1'b0;
      ch0_line_tx_ring <= 1'b0;
      monitoring_active <= 1'b0;
    end else begin
      ch0_cdr_in <= cdr_src;
      ch0_los_in <= cdr_src;
      ch0_receive_data_pos_out <= ch0_cdr_data.pos;
      ch0_receive_data_neg_out <= ch0_cdr_data.neg;
      ch0_line_tx_tip <= tx_src.pos;
      ch0_line_tx_ring <= tx_src.neg;
      monitoring_active <= mon_on;
    end
  end
  // Recovered clock passes straight through; retiming it on clk would destroy it
  assign ch0_receive_clock_out = ch0_cdr_clock;

  assign analog_loop_config = cfg_q[OFS_ANALOG_LOOP];
  assign remote_loop_config = cfg_q[OFS_REMOTE_LOOP];
  assign digital_loop_config = cfg_q[OFS_DIGITAL_LOOP];
  assign all_ones_transmit_config = cfg_q[OFS_ALL_ONES_TX];
  assign auto_all_ones_config = cfg_q[OFS_AUTO_ALL_ONES];
  assign loss_alarm_criteria = cfg_q[OFS_LOSS_ALARM_CRITERIA];
  assign global_config = cfg_q[OFS_GLOBAL_CONFIG];
  assign output_enable_config = cfg_q[OFS_OUTPUT_ENABLE];
  assign software_reset_pulse = srst_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  bank_select_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && is_ptr && req.wdata == BANK_EXPANDED) |=> expanded) else $error("bank not expanded");
  bank_return_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req.wr && is_ptr && req.wdata == BANK_PRIMARY) |=> !expanded) else $error("bank not primary");
  soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    srst_wr |=> software_reset_pulse ##1 (analog_loop_config == 8'h00)) else $error("soft reset missed");
  reserved_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (par_mode && par_rd && !expanded && (par_sel_addr == 5'h10 || par_sel_addr == 5'h16))
    |=> par_data_out == 8'h00) else $error("reserved read not zero");
  id_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (par_mode && par_rd && !expanded && par_sel_addr == OFS_DEVICE_IDENTITY)
    |=> par_data_valid && par_data_out == DEVICE_ID) else $error("identity read wrong");
  flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((signal_loss_in[0] != stat_q[0][0]) && mask[0][0]) |=> flag_q[0][0] ##1 int_oe) else $error("flag not set");
  flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_clr[1] && ((short_circuit_in ^ stat_q[1]) & mask[1]) == 8'h00) |=> flag_q[1] == 8'h00)
    else $error("flag not cleared");
  int_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pend == 3'b000) |=> !int_oe) else $error("interrupt held");
  monitor_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    mon_on |=> ch0_los_in == $past(mon_sig) && ch0_cdr_in == $past(mon_sig)) else $error("monitor route wrong");
  monitor_loop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mon_on && rl0) |=> ch0_line_tx_tip == $past(mon_sig.pos)) else $error("monitor loop wrong");
  upper_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (host_mode == MODE_PAR_DEMUX) |-> req.addr == par_addr[4:0]) else $error("address bits wrong");
endmodule

// [line_unit_regmap_monitor_tb.sv]
// Self-checking bench for the register bank, interrupt flags and monitor select.
// Assumes host_port_model for all host traffic; other inputs change at falling edges.
`timescale 1ns/10ps
module line_unit_regmap_monitor_tb;
  import line_unit_pkg::*;
  localparam logic [7:0] TB_ID = 8'h3C; // Arbitrary value
  localparam logic [7:0] RW_OFS [12] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0B,
                                         8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h12, 8'h14};
  localparam logic [7:0] STS [3] = '{8'h04, 8'h05, 8'h13};
  localparam logic [7:0] MSK [3] = '{8'h06, 8'h07, 8'h14};
  localparam logic [7:0] FLG [3] = '{8'h08, 8'h09, 8'h15};
  localparam logic [7:0] RSV [4] = '{8'h10, 8'h11, 8'h16, 8'h1E};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  host_mode_t host_mode = MODE_PAR_DEMUX;
  logic par_rd, par_wr, par_ale, par_data_valid, ser_clk, ser_cs_n, ser_di, ser_do;
  logic [7:0] par_addr, par_data_in, par_data_out;
  logic [7:0] signal_loss_in = 8'h00;
  logic [7:0] short_circuit_in = 8'h00;
  logic [7:0] alarm_signal_in = 8'h00;
  logic [3:0] monitor_path_select_pins = 4'h0;
  rail_pair_t [7:0] line_rx_in = 16'h5555;
  rail_pair_t [7:0] line_tx_in = 16'h5555;
  logic ch0_cdr_clock = 1'b0;
  rail_pair_t ch0_cdr_data = 2'b00;
  rail_pair_t ch0_cdr_in, ch0_los_in;
  logic int_out, int_oe, ch0_receive_clock_out, ch0_receive_data_pos_out, ch0_receive_data_neg_out;
  logic ch0_line_tx_tip, ch0_line_tx_ring, monitoring_active, software_reset_pulse;
  logic [7:0] analog_loop_config, remote_loop_config, digital_loop_config, all_ones_transmit_config;
  logic [7:0] auto_all_ones_config, loss_alarm_criteria, global_config, output_enable_config;
  int num_errors = 0;
  int n_checks = 0;

  always #4 clk = ~clk;

  line_unit_regmap_monitor #(.DEVICE_ID(TB_ID)) u_line_unit_regmap_monitor (.clk, .rst_n, .host_mode,
    .par_rd, .par_wr, .par_ale, .par_addr, .par_data_in, .par_data_out, .par_data_valid, .ser_clk,
    .ser_cs_n, .ser_di, .ser_do, .signal_loss_in, .short_circuit_in, .alarm_signal_in, .int_out, .int_oe,
    .monitor_path_select_pins, .line_rx_in, .line_tx_in, .ch0_cdr_clock, .ch0_cdr_data, .ch0_cdr_in,
    .ch0_los_in, .ch0_receive_clock_out, .ch0_receive_data_pos_out, .ch0_receive_data_neg_out,
    .ch0_line_tx_tip, .ch0_line_tx_ring, .analog_loop_config, .remote_loop_config, .digital_loop_config,
    .all_ones_transmit_config, .auto_all_ones_config, .loss_alarm_criteria, .global_config,
    .output_enable_config, .monitoring_active, .software_reset_pulse);

  host_port_model u_host_port_model (.clk, .mux_sel(host_mode == MODE_PAR_MUX), .par_rd, .par_wr,
    .par_ale, .par_addr, .par_data_in, .par_data_out, .par_data_valid, .ser_clk, .ser_cs_n, .ser_di,
    .ser_do);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host_port_model.read(a, d);
    chk8(d, exp);
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdchk(8'h00, TB_ID);
    u_host_port_model.write(8'h00, 8'hFF);
    rdchk(8'h00, TB_ID);
    foreach (RW_OFS[i]) u_host_port_model.write(RW_OFS[i], 8'hA0 + 8'(i));
    foreach (RW_OFS[i]) rdchk(RW_OFS[i], 8'hA0 + 8'(i));
    chk8(output_enable_config, 8'hAA);
    chk8(remote_loop_config, 8'hA1);
    chk8(all_ones_transmit_config, 8'hA2);
    chk8(digital_loop_config, 8'hA6);
    chk8(loss_alarm_criteria, 8'hA7);
    chk8(auto_all_ones_config, 8'hA8);
    chk8(global_config, 8'hA9);
    foreach (STS[k]) u_host_port_model.write(STS[k], 8'hFF);
    rdchk(8'h04, 8'h00);
    foreach (FLG[k]) u_host_port_model.write(FLG[k], 8'hFF);
    rdchk(8'h15, 8'h00);
    foreach (RSV[k]) u_host_port_model.write(RSV[k], 8'hFF);
    rdchk(8'h10, 8'h00);
    rdchk(8'h11, 8'h00);
    rdchk(8'h16, 8'h00);
    rdchk(8'h1E, 8'h00);
    chk8(output_enable_config, 8'hAA);
    u_host_port_model.write(8'hE1, 8'h5C);
    rdchk(8'h01, 8'h5C);
    chk8(analog_loop_config, 8'h5C);
  endtask

  task automatic t_hosts();
    logic [7:0] q;
    @(negedge clk);
    host_mode = MODE_PAR_MUX;
    u_host_port_model.write(8'hE3, 8'h96);
    rdchk(8'hA3, 8'h96);
    @(negedge clk);
    host_mode = MODE_SERIAL;
    u_host_port_model.ser_xfer(1'b0, 5'h0C, 8'hB4, q);
    u_host_port_model.ser_xfer(1'b1, 5'h0C, 8'h00, q);
    chk8(q, 8'hB4);
    u_host_port_model.ser_xfer(1'b1, 5'h00, 8'h00, q);
    chk8(q, TB_ID);
    @(negedge clk);
    host_mode = MODE_PAR_DEMUX;
    rdchk(8'h0C, 8'hB4);
  endtask

  task automatic t_bank();
    u_host_port_model.write(8'h1F, 8'hAA);
    rdchk(8'h1F, 8'hAA);
    u_host_port_model.write(8'h01, 8'h77);
    rdchk(8'h01, 8'h77);
    chk8(analog_loop_config, 8'h5C);
    u_host_port_model.write(8'h1F, 8'h00);
    rdchk(8'h01, 8'h5C);
    rdchk(8'h1F, 8'h00);
  endtask

  task automatic set_src(input int k, input logic [7:0] v);
    @(negedge clk);
    case (k)
      0: signal_loss_in = v;
      1: short_circuit_in = v;
      default: alarm_signal_in = v;
    endcase
    repeat (4) @(negedge clk);
  endtask

  task automatic t_irq();
    foreach (STS[k]) begin
      u_host_port_model.write(MSK[k], 8'h01);
      set_src(k, 8'h03);
      chk1(int_oe, 1'b1);
      chk1(int_out, 1'b0);
      rdchk(FLG[k], 8'h01);
      rdchk(STS[k], 8'h03);
      rdchk(FLG[k], 8'h00);
      chk1(int_oe, 1'b0);
      set_src(k, 8'h00);
      rdchk(FLG[k], 8'h01);
      rdchk(STS[k], 8'h00);
      u_host_port_model.write(MSK[k], 8'h00);
    end
  endtask

  task automatic t_swrst();
    logic seen;
    seen = 1'b0;
    u_host_port_model.write(8'h0A, 8'h01);
    repeat (4) begin
      seen = seen | (software_reset_pulse === 1'b1);
      @(negedge clk);
    end
    chk1(seen, 1'b1);
    rdchk(8'h01, 8'h00);
    chk8(global_config, 8'h00);
  endtask

  task automatic t_mon();
    @(negedge clk);
    line_rx_in[3] = 2'b10;
    line_tx_in[5] = 2'b11;
    line_tx_in[3] = 2'b00;
    ch0_cdr_data = 2'b01;
    ch0_cdr_clock = 1'b1;
    u_host_port_model.write(8'h0B, 8'h03);
    u_host_port_model.write(8'h02, 8'h01);
    repeat (4) @(negedge clk);
    chk1(monitoring_active, 1'b1);
    chk8(8'(ch0_cdr_in), 8'h02);
    chk8(8'(ch0_los_in), 8'h02);
    chk1(ch0_receive_clock_out, 1'b1);
    chk8(8'({ch0_receive_data_pos_out, ch0_receive_data_neg_out}), 8'h01);
    chk8(8'({ch0_line_tx_tip, ch0_line_tx_ring}), 8'h02);
    u_host_port_model.write(8'h0B, 8'h0D);
    repeat (4) @(negedge clk);
    chk8(8'(ch0_cdr_in), 8'h03);
    host_mode = MODE_HARDWARE;
    monitor_path_select_pins = 4'hB;
    repeat (8) @(negedge clk);
    chk8(8'(ch0_los_in), 8'h00);
    monitor_path_select_pins = 4'h0;
    ch0_cdr_clock = 1'b0;
    repeat (8) @(negedge clk);
    chk1(monitoring_active, 1'b0);
    chk8(8'(ch0_cdr_in), 8'h01);
    chk1(ch0_receive_clock_out, 1'b0);
    chk8(8'({ch0_line_tx_tip, ch0_line_tx_ring}), 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_hosts();
    t_bank();
    t_irq();
    t_swrst();
    t_mon();
    wrap_up();
  end

  // Run needs about 850 cycles; limit leaves ample margin
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
endmodule
